// ---- hdl/phy_cfg_top.sv ----
// DDR3 PHY termination, training and impedance configuration
// What this block does
// - Write to rank n drives all four rank terminations from write field n.
// - Read to rank n drives all four rank terminations from read field n.
// - In each termination field bit 0 is rank 0, bit 3 rank 3; one enables.
// - Write fields reset one-hot: rank 3 at 0x8 down to rank 0 at 0x1.
// - Read fields reset to zero, no termination during reads.
// - Non-zero refresh count sends that many refreshes after each rank except last.
// - Only ranks set in the training rank mask are trained.
// - Extended strobe adds two postamble strobe pulses after training write bursts.
// - Writing one to debug step advances training one step, then self-clears.
// - Debug enable runs training in debug mode; byte select picks the lane.
// - Centering bit adds eye centering; mask bit includes data mask deskew.
// - Write data delay steps up and wraps back to margin once past twice calibration value less margin.
// - Compare-data makes gate training check data, else only strobe edges.
// - Pattern-register bit makes gate training read the memory pattern register.
// - Deskew rank field picks training rank; repeat field sets confirmations.
// - Impedance power-down bit powers down the impedance control block.
// - Calibration runs on a trigger only when enabled; enable resets to one.
// - Bypass bit abandons a calibration already in progress.
// - Override enable drives impedance code from override data, else calibration.
// - Override data splits into four 7-bit codes; resets to 0x014a.
// - Periodic update bit makes the block request periodic updates.
// - Divide ratio: upper nibble termination divide, lower nibble output divide.
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module phy_cfg_top #(
    parameter int RANKS = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        link_clk,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_is_write,
    input  wire logic [1:0]  cmd_rank,
    input  wire logic        dfi_update_req,
    output logic [RANKS-1:0] rank_term_en,
    output logic             train_busy,
    output logic             train_refresh,
    output logic             train_step,
    output logic [1:0]       train_rank,
    output logic             train_ext_strobe,
    output logic             train_debug_mode,
    output logic [3:0]       train_byte_sel,
    output logic             train_centering,
    output logic             train_mask_deskew,
    output logic [7:0]       wdq_delay,
    output logic             train_compare_data,
    output logic             train_use_pattern,
    output logic [1:0]       train_deskew_rank,
    output logic [3:0]       train_repeat_count,
    output logic             imp_power_down,
    output phy_cfg_pkg::imp_code_t imp_code,
    output logic             periodic_update_req,
    output logic [3:0]       term_divide,
    output logic [3:0]       out_divide
);
    import phy_cfg_pkg::*;
    typedef struct packed {
        logic [31:0]     odt_rank_config_r;
        logic [31:0]     data_training_config_r;
        logic [31:0]     impedance_control_0_r;
        logic [31:0]     impedance_control_1_r;
        logic [31:0]     rdata_r;
        logic [2:0]      lclk_sync_r;
        logic            lclk_seen_r;
        logic [RANKS-1:0] term_r;
        logic            train_start_r;
        logic            cal_trig_r;
        logic            step_pend_r;
        logic            ext_post_r;
        logic [7:0]      wdq_r;
        logic [7:0]      wdq_cal_r;
        logic [1:0]      ext_cnt_r;
        logic            train_done_r;
        logic            cal_done_r;
    } top_state_t;
    top_state_t s_r, s_nxt;
    imp_cal_if cal ();
    logic       seq_busy;
    logic       seq_done;
    logic       seq_step;
    logic       seq_rfsh;
    logic [1:0] seq_rank;
    logic [3:0] wdqm;
    logic [7:0] wdq_hi;
    logic [7:0] wdq_lo;
    logic [7:0] wdq_try;
    train_sequencer u_seq (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .start         (s_r.train_start_r),
        .rank_mask     (s_r.data_training_config_r[`TRAIN_RANK_MASK_LSB +: 4]),
        .refresh_burst (s_r.data_training_config_r[`RFSH_LSB +: 4]),
        .debug_en      (s_r.data_training_config_r[`DDEN_BIT]),
        .debug_step    (s_r.step_pend_r & ~seq_step),
        .busy          (seq_busy),
        .done          (seq_done),
        .step_pulse    (seq_step),
        .refresh_pulse (seq_rfsh),
        .cur_rank      (seq_rank)
    );
    imp_cal_engine u_cal (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cal     (cal.eng)
    );
    // Calibration triggers come from software or the DFI update port
    assign cal.trigger    = s_r.cal_trig_r | dfi_update_req;
    assign cal.enable     = s_r.impedance_control_0_r[`IMP_CAL_ENABLE_BIT];
    assign cal.bypass     = s_r.impedance_control_0_r[`IMP_CAL_BYPASS_BIT];
    assign cal.power_down = s_r.impedance_control_0_r[`IMP_BLOCK_POWER_DOWN_BIT];
    assign wdqm = s_r.data_training_config_r[`WDQM_LSB +: 4];
    assign wdq_lo = {4'h0, wdqm};
    assign wdq_hi = {s_r.wdq_cal_r[6:0], 1'b0} - {4'h0, wdqm};
    assign wdq_try = s_r.wdq_r + 8'h01;
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata_r       = 32'h0000_0000;
        s_nxt.train_start_r = 1'b0;
        s_nxt.cal_trig_r    = 1'b0;
        s_nxt.lclk_sync_r   = {s_r.lclk_sync_r[1:0], link_clk};
        // Link clock only counts as running once two later stages agree
        if (s_r.lclk_sync_r[2] == s_r.lclk_sync_r[1]) begin
            s_nxt.lclk_seen_r = s_r.lclk_sync_r[1];
        end
        if (cmd_valid) begin
            s_nxt.term_r = cmd_is_write ?
                s_r.odt_rank_config_r[`WR_TERM_LSB + 4*cmd_rank +: 4] :
                s_r.odt_rank_config_r[4*cmd_rank +: 4];
        end else begin
            s_nxt.term_r = '0;
        end
        if (seq_step) begin
            s_nxt.step_pend_r = 1'b0;
        end
        if (seq_done) begin
            s_nxt.train_done_r = 1'b1;
        end
        if (cal.done) begin
            s_nxt.cal_done_r = 1'b1;
            s_nxt.wdq_cal_r  = {1'b0, cal.code[6:0]};
        end
        if (seq_step) begin
            // Past the upper bound the delay wraps back to the lower bound
            s_nxt.wdq_r = (wdq_try > wdq_hi) ? wdq_lo : wdq_try;
        end
        if (seq_step && s_r.data_training_config_r[`EXTD_BIT]) begin
            s_nxt.ext_cnt_r = 2'd2;
        end else if (s_r.ext_cnt_r != 2'd0) begin
            s_nxt.ext_cnt_r = s_r.ext_cnt_r - 2'd1;
        end
        s_nxt.ext_post_r = (s_r.ext_cnt_r != 2'd0);
        if (reg_wr) begin
            unique case (reg_addr)
                `ODT_RANK_CONFIG_OFS: s_nxt.odt_rank_config_r = reg_wdata;
                `DATA_TRAINING_CONFIG_OFS: begin
                    s_nxt.data_training_config_r = reg_wdata & `DTC_WMASK;
                    s_nxt.data_training_config_r[`DSTP_BIT] = 1'b0;
                    if (reg_wdata[`DSTP_BIT]) begin
                        s_nxt.step_pend_r = 1'b1;
                    end
                end
                `IMPEDANCE_CONTROL_0_OFS: s_nxt.impedance_control_0_r = reg_wdata & `ZQ0_WMASK;
                `IMPEDANCE_CONTROL_1_OFS:
                    s_nxt.impedance_control_1_r = reg_wdata & `ZQ1_WMASK;
                `TRAIN_CONTROL_OFS: begin
                    s_nxt.train_start_r = reg_wdata[0] & ~seq_busy;
                    s_nxt.cal_trig_r    = reg_wdata[1];
                    // Set wins over clear
                    if (reg_wdata[2] && !seq_done) begin
                        s_nxt.train_done_r = 1'b0;
                    end
                    if (reg_wdata[3] && !cal.done) begin
                        s_nxt.cal_done_r = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `ODT_RANK_CONFIG_OFS:      s_nxt.rdata_r = s_r.odt_rank_config_r;
                `DATA_TRAINING_CONFIG_OFS: s_nxt.rdata_r = s_r.data_training_config_r;
                `IMPEDANCE_CONTROL_0_OFS:  s_nxt.rdata_r = s_r.impedance_control_0_r;
                `IMPEDANCE_CONTROL_1_OFS:  s_nxt.rdata_r = s_r.impedance_control_1_r;
                `TRAIN_STATUS_OFS: s_nxt.rdata_r = {24'h0, s_r.wdq_r[3:0], seq_rank,
                                                    s_r.train_done_r, seq_busy};
                `IMP_STATUS_OFS: s_nxt.rdata_r = {2'b0, s_r.cal_done_r, cal.busy,
                                                  cal.code};
                default: s_nxt.rdata_r = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.odt_rank_config_r      <= `ODT_RANK_CONFIG_RST;
            s_r.data_training_config_r <= `DATA_TRAINING_CONFIG_RST;
            s_r.impedance_control_0_r  <= `IMPEDANCE_CONTROL_0_RST;
            s_r.impedance_control_1_r  <= `IMPEDANCE_CONTROL_1_RST;
            s_r.rdata_r       <= 32'h0000_0000;
            s_r.lclk_sync_r   <= 3'h0;
            s_r.lclk_seen_r   <= 1'b0;
            s_r.term_r        <= '0;
            s_r.train_start_r <= 1'b0;
            s_r.cal_trig_r    <= 1'b0;
            s_r.step_pend_r   <= 1'b0;
            s_r.ext_post_r    <= 1'b0;
            s_r.wdq_r         <= 8'h00;
            s_r.wdq_cal_r     <= 8'h4a;
            s_r.ext_cnt_r     <= 2'd0;
            s_r.train_done_r  <= 1'b0;
            s_r.cal_done_r    <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign reg_rdata          = s_r.rdata_r;
    assign rank_term_en       = s_r.term_r;
    assign train_busy         = seq_busy;
    assign train_refresh      = seq_rfsh;
    assign train_step         = seq_step;
    assign train_rank         = seq_rank;
    assign train_ext_strobe   = s_r.ext_post_r;
    assign train_debug_mode   = s_r.data_training_config_r[`DDEN_BIT];
    assign train_byte_sel     = s_r.data_training_config_r[`DBS_LSB +: 4];
    assign train_centering    = s_r.data_training_config_r[`BDC_BIT];
    assign train_mask_deskew  = s_r.data_training_config_r[`WBDDM_BIT];
    assign wdq_delay          = s_r.wdq_r;
    assign train_compare_data = s_r.data_training_config_r[`CMPD_BIT];
    assign train_use_pattern  = s_r.data_training_config_r[`MPR_BIT];
    assign train_deskew_rank  = s_r.data_training_config_r[`DRANK_LSB +: 2];
    assign train_repeat_count = s_r.data_training_config_r[3:0];
    assign imp_power_down     = s_r.impedance_control_0_r[`IMP_BLOCK_POWER_DOWN_BIT];
    assign imp_code = s_r.impedance_control_0_r[`IMP_OVERRIDE_ENABLE_BIT] ?
                      s_r.impedance_control_0_r[27:0] : cal.code;
    assign periodic_update_req = s_r.impedance_control_1_r[`DFIPU_BIT];
    assign term_divide        = s_r.impedance_control_1_r[7:4];
    assign out_divide         = s_r.impedance_control_1_r[3:0];
endmodule
`default_nettype wire

// ---- hdl/phy_cfg_map.svh ----
// Register offsets, field positions, reset values and counts of the PHY configuration block
`ifndef PHY_CFG_MAP_SVH
`define PHY_CFG_MAP_SVH
`define ODT_RANK_CONFIG_OFS      8'h00
`define DATA_TRAINING_CONFIG_OFS 8'h04
`define IMPEDANCE_CONTROL_0_OFS  8'h08
`define IMPEDANCE_CONTROL_1_OFS  8'h0c
`define TRAIN_CONTROL_OFS        8'h10
`define TRAIN_STATUS_OFS         8'h14
`define IMP_STATUS_OFS           8'h18
`define ODT_RANK_CONFIG_RST      32'h8421_0000
`define DATA_TRAINING_CONFIG_RST 32'h0f00_0000
`define IMPEDANCE_CONTROL_0_RST  32'h4000_014a
`define IMPEDANCE_CONTROL_1_RST  32'h0001_007b
`define DTC_WMASK                32'hff7f_3fff
`define ZQ0_WMASK                32'hffff_ffff
`define ZQ1_WMASK                32'h0001_00ff
`define WR_TERM_LSB              16
`define RFSH_LSB                 28
`define TRAIN_RANK_MASK_LSB               24
`define EXTD_BIT                 22
`define DSTP_BIT                 21
`define DDEN_BIT                 20
`define DBS_LSB                  16
`define BDC_BIT                  13
`define WBDDM_BIT                12
`define WDQM_LSB                 8
`define CMPD_BIT                 7
`define MPR_BIT                  6
`define DRANK_LSB                4
`define IMP_BLOCK_POWER_DOWN_BIT                 31
`define IMP_CAL_ENABLE_BIT               30
`define IMP_CAL_BYPASS_BIT              29
`define IMP_OVERRIDE_ENABLE_BIT                 28
`define DFIPU_BIT                16
`define REFRESH_SPACING          8'h04
`define CAL_CYCLES               8'h20
`define TRAIN_STEP_CYCLES        8'h08
`endif

// ---- hdl/phy_cfg_pkg.sv ----
// Types shared by the PHY configuration block
package phy_cfg_pkg;
    typedef enum logic [2:0] {
        TR_IDLE  = 3'b000,
        TR_PICK  = 3'b001,
        TR_STEP  = 3'b010,
        TR_RFSH  = 3'b011,
        TR_DONE  = 3'b100
    } train_state_t;
    typedef struct packed {
        logic [6:0] term_pull_up;
        logic [6:0] term_pull_down;
        logic [6:0] out_pull_up;
        logic [6:0] out_pull_down;
    } imp_code_t;
endpackage

// ---- hdl/imp_cal_if.sv ----
// Carrier between the top and the impedance calibration engine
`timescale 1ns/1ps
`default_nettype none
interface imp_cal_if;
    logic       trigger;
    logic       enable;
    logic       bypass;
    logic       power_down;
    logic       busy;
    logic       done;
    logic [27:0] code;
    modport ctrl (output trigger, output enable, output bypass, output power_down,
                  input busy, input done, input code);
    modport eng  (input trigger, input enable, input bypass, input power_down,
                  output busy, output done, output code);
endinterface
`default_nettype wire

// ---- hdl/imp_cal_engine.sv ----
// Automatic impedance calibration sequencer for one control block
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module imp_cal_engine (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    imp_cal_if.eng    cal
);
    import phy_cfg_pkg::*;
    typedef struct packed {
        logic        busy_r;
        logic        done_r;
        logic [7:0]  cnt_r;
        logic [27:0] code_r;
    } cal_state_t;
    cal_state_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.done_r = 1'b0;
        if (cal.power_down) begin
            s_nxt.busy_r = 1'b0;
        end else if (s_r.busy_r) begin
            if (cal.bypass) begin
                // Abandon keeps the last good code
                s_nxt.busy_r = 1'b0;
            end else if (s_r.cnt_r == 8'h00) begin
                s_nxt.busy_r = 1'b0;
                s_nxt.done_r = 1'b1;
                s_nxt.code_r = 28'(`IMPEDANCE_CONTROL_0_RST);
            end else begin
                s_nxt.cnt_r = s_r.cnt_r - 8'h01;
            end
        end else if (cal.trigger && cal.enable) begin
            s_nxt.busy_r = 1'b1;
            s_nxt.cnt_r  = `CAL_CYCLES;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{busy_r: 1'b0, done_r: 1'b0, cnt_r: 8'h00, code_r: 28'h000014a};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign cal.busy = s_r.busy_r;
    assign cal.done = s_r.done_r;
    assign cal.code = s_r.code_r;
endmodule
`default_nettype wire

// ---- hdl/train_sequencer.sv ----
// Rank walk of data training with refresh bursts between ranks
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module train_sequencer (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [3:0] rank_mask,
    input  wire logic [3:0] refresh_burst,
    input  wire logic       debug_en,
    input  wire logic       debug_step,
    output logic            busy,
    output logic            done,
    output logic            step_pulse,
    output logic            refresh_pulse,
    output logic [1:0]      cur_rank
);
    import phy_cfg_pkg::*;
    typedef struct packed {
        train_state_t st_r;
        logic [1:0]   rank_r;
        logic [3:0]   left_r;
        logic [3:0]   rfsh_r;
        logic [7:0]   cnt_r;
        logic         done_r;
        logic         step_r;
        logic         rfsh_p_r;
    } seq_state_t;
    seq_state_t s_r, s_nxt;
    logic [3:0] rest;
    always_comb begin
        s_nxt = s_r;
        s_nxt.done_r   = 1'b0;
        s_nxt.step_r   = 1'b0;
        s_nxt.rfsh_p_r = 1'b0;
        rest = s_r.left_r & ~(4'h1 << s_r.rank_r);
        unique case (s_r.st_r)
            TR_IDLE: if (start) begin
                s_nxt.left_r = rank_mask;
                s_nxt.st_r   = TR_PICK;
            end
            TR_PICK: begin
                if (s_r.left_r == 4'h0) begin
                    s_nxt.st_r = TR_DONE;
                end else begin
                    s_nxt.rank_r = s_r.left_r[0] ? 2'd0 : s_r.left_r[1] ? 2'd1 :
                                   s_r.left_r[2] ? 2'd2 : 2'd3;
                    s_nxt.cnt_r  = `TRAIN_STEP_CYCLES;
                    s_nxt.st_r   = TR_STEP;
                end
            end
            TR_STEP: begin
                // Debug mode holds each step until software steps it
                if (!debug_en || debug_step) begin
                    s_nxt.step_r = 1'b1;
                    if (s_r.cnt_r == 8'h00) begin
                        s_nxt.left_r = rest;
                        s_nxt.rfsh_r = refresh_burst;
                        s_nxt.cnt_r  = 8'h00;
                        // No refresh burst after the last rank
                        s_nxt.st_r   = (rest != 4'h0 && refresh_burst != 4'h0) ?
                                       TR_RFSH : TR_PICK;
                    end else begin
                        s_nxt.cnt_r = s_r.cnt_r - 8'h01;
                    end
                end
            end
            TR_RFSH: begin
                if (s_r.cnt_r == 8'h00) begin
                    s_nxt.rfsh_p_r = 1'b1;
                    s_nxt.rfsh_r   = s_r.rfsh_r - 4'h1;
                    s_nxt.cnt_r    = `REFRESH_SPACING;
                    if (s_r.rfsh_r == 4'h1) begin
                        s_nxt.st_r = TR_PICK;
                    end
                end else begin
                    s_nxt.cnt_r = s_r.cnt_r - 8'h01;
                end
            end
            TR_DONE: begin
                s_nxt.done_r = 1'b1;
                s_nxt.st_r   = TR_IDLE;
            end
            default: s_nxt.st_r = TR_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st_r: TR_IDLE, rank_r: 2'd0, left_r: 4'h0, rfsh_r: 4'h0,
                     cnt_r: 8'h00, done_r: 1'b0, step_r: 1'b0, rfsh_p_r: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign busy          = (s_r.st_r != TR_IDLE);
    assign done          = s_r.done_r;
    assign step_pulse    = s_r.step_r;
    assign refresh_pulse = s_r.rfsh_p_r;
    assign cur_rank      = s_r.rank_r;
endmodule
`default_nettype wire

// ---- bench/phy_cfg_properties.sv ----
// Port-level assertions for the PHY configuration block
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_properties #(
    parameter int RANKS = 4
) (
    input wire logic             sys_clk,
    input wire logic             rst_n,
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [31:0]      reg_rdata,
    input wire logic             cmd_valid,
    input wire logic [RANKS-1:0] rank_term_en,
    input wire logic             train_refresh,
    input wire logic             train_busy,
    input wire logic [27:0]      imp_code,
    input wire logic             imp_power_down,
    input wire logic             periodic_update_req,
    input wire logic [3:0]       term_divide,
    input wire logic [3:0]       out_divide,
    input wire logic             train_debug_mode,
    input wire logic [3:0]       train_byte_sel
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    term_idle_a: assert property (!cmd_valid |=> rank_term_en == '0)
        else $error("termination on without a command");
    unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    dtc_reserved_a: assert property (
        reg_rd && reg_addr == 8'h04 |=> {reg_rdata[23], reg_rdata[21], reg_rdata[15:14]} == 4'h0)
        else $error("reserved or step bit reads set");
    rfsh_in_train_a: assert property (train_refresh |-> train_busy)
        else $error("refresh outside training");
    override_code_a: assert property (
        reg_wr && reg_addr == 8'h08 && reg_wdata[28] |=> imp_code == $past(reg_wdata[27:0]))
        else $error("override code not driven");
    power_down_a: assert property (
        reg_wr && reg_addr == 8'h08 |=> imp_power_down == $past(reg_wdata[31]))
        else $error("power down not following register");
    zq1_fields_a: assert property (
        reg_wr && reg_addr == 8'h0c |=> {periodic_update_req, term_divide, out_divide}
            == {$past(reg_wdata[16]), $past(reg_wdata[7:0])})
        else $error("update or divide fields wrong");
    debug_sel_a: assert property (
        reg_wr && reg_addr == 8'h04 |=> {train_debug_mode, train_byte_sel} == $past(reg_wdata[20:16]))
        else $error("debug mode or byte select wrong");
endmodule
bind phy_cfg_top phy_cfg_properties #(.RANKS(RANKS)) phy_cfg_properties_inst (.*);
`default_nettype wire

// ---- bench/ddr3_rank_model.sv ----
// Behavioural memory ranks: count the refresh commands they receive
`timescale 1ns/1ps
`default_nettype none
module ddr3_rank_model (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic refresh,
    output var int    refresh_count
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_count <= 0;
        end else if (refresh) begin
            refresh_count <= refresh_count + 1;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_phy_cfg_top.sv ----
// Self-checking bench for the PHY configuration block
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module tb_phy_cfg_top;
    import phy_cfg_pkg::*;
    logic        sys_clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, dfi_update_req = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0, cmd_is_write = 1'b0;
    logic [1:0]  cmd_rank = 2'h0, train_rank, train_deskew_rank;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
    logic [3:0]  rank_term_en, train_byte_sel, train_repeat_count;
    logic        train_busy, train_refresh, train_step, train_debug_mode, train_centering,
                 train_mask_deskew, train_compare_data, train_use_pattern;
    imp_code_t   imp_code;
    int          n_errors = 0, total_checks = 0, n_step = 0, cyc = 0, rfsh, base;

    phy_cfg_top phy_cfg_top_inst (.*, .train_ext_strobe(), .wdq_delay(), .imp_power_down(),
        .periodic_update_req(), .term_divide(), .out_divide());
    ddr3_rank_model ddr3_rank_model_inst (.sys_clk, .rst_n, .refresh(train_refresh),
        .refresh_count(rfsh));

    initial forever #5 sys_clk = ~sys_clk;
    // Free-running, every edge lands on a sys_clk falling edge
    initial forever #40 link_clk = ~link_clk;
    // Counted clear of the driving edge
    always @(negedge sys_clk) if (train_step === 1'b1) n_step++;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        rdv = reg_rdata;
    endtask
    task automatic cmd(input logic w, input logic [1:0] r);
        @(posedge sys_clk);
        cmd_valid    <= 1'b1;
        cmd_is_write <= w;
        cmd_rank     <= r;
        @(posedge sys_clk);
        cmd_valid    <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && train_busy !== 1'b0; i++) @(negedge sys_clk);
    endtask
    task automatic pulse_dfi();
        @(posedge sys_clk);
        dfi_update_req <= 1'b1;
        @(posedge sys_clk);
        dfi_update_req <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] e[4] = '{`ODT_RANK_CONFIG_RST, `DATA_TRAINING_CONFIG_RST,
                              `IMPEDANCE_CONTROL_0_RST, `IMPEDANCE_CONTROL_1_RST};
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i));
            chk("reset value", rdv, e[i]);
        end
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40);
        chk("unmapped", rdv, 32'h0);
    endtask
    task automatic t_fields();
        logic [31:0] p = 32'h5ae9_d3a6;
        wr(8'h04, p);
        rd(8'h04);
        chk("dtc mask", rdv, p & `DTC_WMASK & 32'hffdf_ffff);
        chk("dtc outs", 32'({train_debug_mode, train_byte_sel, train_centering, train_mask_deskew,
            train_compare_data, train_use_pattern, train_deskew_rank, train_repeat_count}),
            32'({p[20:16], p[13:12], p[7:0]}));
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c);
        chk("zq1 mask", rdv, `ZQ1_WMASK);
    endtask
    task automatic t_odt();
        // Distinct nibbles catch a wrong select
        logic [31:0] v = 32'h3c96_5a1e;
        wr(8'h00, v);
        for (int r = 0; r < 4; r++) begin
            cmd(1'b1, 2'(r));
            chk("write term", 32'(rank_term_en), 32'(v[16 + 4 * r +: 4]));
            cmd(1'b0, 2'(r));
            chk("read term", 32'(rank_term_en), 32'(v[4 * r +: 4]));
        end
    endtask
    task automatic t_train();
        wr(8'h04, 32'h3500_0000);
        @(negedge sys_clk);
        n_step = 0;
        base = rfsh;
        wr(8'h10, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk("train busy", 32'(train_busy), 32'h1);
        wait_idle();
        chk("steps", 32'(n_step), 32'd18);
        chk("refreshes", 32'(rfsh - base), 32'd3);
        chk("last rank", 32'(train_rank), 32'h2);
    endtask
    task automatic t_debug();
        wr(8'h04, 32'h0110_0000);
        wr(8'h10, 32'h1);
        repeat (20) @(negedge sys_clk);
        n_step = 0;
        wr(8'h04, 32'h0130_0000);
        repeat (20) @(negedge sys_clk);
        chk("debug step", 32'(n_step), 32'h1);
        wr(8'h04, 32'h0100_0000);
        wait_idle();
    endtask
    task automatic t_cal();
        wr(8'h10, 32'h2);
        rd(8'h18);
        chk("cal busy", 32'(rdv[28]), 32'h1);
        wr(8'h08, 32'h6000_014a);
        rd(8'h18);
        chk("cal abort", 32'(rdv[28]), 32'h0);
        wr(8'h08, 32'h0000_014a);
        pulse_dfi();
        rd(8'h18);
        chk("cal disabled", 32'(rdv[28]), 32'h0);
        wr(8'h08, `IMPEDANCE_CONTROL_0_RST);
        pulse_dfi();
        rd(8'h18);
        chk("dfi trigger", 32'(rdv[28]), 32'h1);
        repeat (40) @(posedge sys_clk);
        wr(8'h08, 32'h9abc_def0);
        @(negedge sys_clk);
        chk("override", 32'(imp_code), 32'h0abc_def0);
        chk("term pull up", 32'(imp_code.term_pull_up), 32'h55);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_odt();
        t_train();
        t_debug();
        t_cal();
        report_and_stop();
    end
endmodule
`default_nettype wire
